// >>> logic/ebr_pkg.sv
// Constants, encodings and field layouts of the multimode embedded memory block
package memblk_pkg;

  // ****************************************************************
  // Operating modes and memory shapes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_RAM  = 3'h0,
    MODE_FIFO = 3'h1,
    MODE_MUL8 = 3'h3,
    MODE_CONST = 3'h2,
    MODE_CAM  = 3'h6
  } mode_e;

  typedef enum logic [2:0] {
    SHAPE_X18   = 3'h0,
    SHAPE_X36   = 3'h1,
    SHAPE_X9    = 3'h3,
    SHAPE_DUAL9 = 3'h2,
    SHAPE_SPLIT = 3'h6
  } shape_e;

  // ****************************************************************
  // Array geometry and byte lanes
  // ****************************************************************
  localparam int WORDS = 512;
  localparam int AW = 9;
  localparam int DW = 18;
  localparam int PW = 10;
  localparam int CW = 11;
  localparam int OPER_W = 16;
  localparam logic [DW-1:0] LANE0_MASK = 18'h100ff;
  localparam logic [DW-1:0] LANE1_MASK = 18'h2ff00;
  localparam logic [DW-1:0] FULL_MASK = 18'h3ffff;
  localparam int LANE0_PAR = 16;
  localparam int LANE1_PAR = 17;
  localparam int LANE1_LSB = 8;
  localparam int BYTE_W = 8;
  localparam int NINE_W = 9;

  // ****************************************************************
  // Queue depths
  // ****************************************************************
  localparam logic [CW-1:0] DEPTH_X36 = 11'h100;
  localparam logic [CW-1:0] DEPTH_X18 = 11'h200;
  localparam logic [CW-1:0] DEPTH_X9 = 11'h400;

  // ****************************************************************
  // Multipliers and content-addressable memory
  // ****************************************************************
  localparam logic [AW-1:0] COEF_WORD = 9'h000;
  localparam int PROD_W = 24;
  localparam int MUL_W = 8;
  localparam int CAM_ENTRIES = 16;
  localparam int CAM_W = 8;
  localparam int CAM_IDX_W = 4;
  localparam int CAM_CLR_BIT = 17;
  localparam int CAM_SINGLE_BIT = 16;

endpackage

// >>> logic/multimode_block_ram.sv
// Multimode embedded memory block: RAM shapes, queue, multipliers, CAM and write arbiter
`timescale 1ns/1ps

module multimode_block_ram #(
  parameter int WORDS_P = memblk_pkg::WORDS
) (
  input wire logic clk_sys,                                 // System clock
  input wire logic sys_rst,                                 // Synchronous reset, active high
  input wire logic ce,                                      // Clock enable
  input wire logic block_rst_n,                             // Block reset, active low
  input wire memblk_pkg::mode_e mode,                       // Operating mode
  input wire memblk_pkg::shape_e shape,                     // Memory shape
  input wire logic [memblk_pkg::AW-1:0] split_words,        // Words of first split RAM
  input wire logic read_reg_en,                             // Register read address / operands
  input wire logic out_reg_en,                              // Extra output register stage
  input wire logic arb_en,                                  // Write arbiter enable
  input wire logic sysbus_mode,                             // Second port owned by system bus
  input wire logic dyn_thr,                                 // Thresholds from address pins
  input wire logic [memblk_pkg::PW-1:0] ae_static,          // Fixed almost-empty offset
  input wire logic [memblk_pkg::PW-1:0] af_static,          // Fixed almost-full offset
  input wire logic const_byte,                              // 8-bit constant times 16-bit operand
  input wire logic [memblk_pkg::OPER_W-1:0] read_address_0, // First port read address / operand
  input wire logic [memblk_pkg::OPER_W-1:0] read_address_1, // Second port read address / operand
  input wire logic [memblk_pkg::PW-1:0] write_address_0,    // First port write address
  input wire logic [memblk_pkg::PW-1:0] write_address_1,    // Second port write address
  input wire logic [1:0] lane_write_enable_0,               // First port lane enables
  input wire logic [1:0] lane_write_enable_1,               // Second port lane enables
  input wire logic read_enable_0,                           // First port read enable
  input wire logic read_enable_1,                           // Second port read enable
  input wire logic write_enable_0,                          // First port write enable
  input wire logic write_enable_1,                          // Second port write enable
  input wire logic [memblk_pkg::DW-1:0] write_data_0,       // First port write data
  input wire logic [memblk_pkg::DW-1:0] write_data_1,       // Second port write data
  output logic [memblk_pkg::DW-1:0] read_data_0,            // First port read data
  output logic [memblk_pkg::DW-1:0] read_data_1,            // Second port read data
  output logic busy,                                        // Second port wrote last cycle (never set in queue or CAM mode, or in X36 or DUAL9 shape)
  output logic [1:0] queue_full_flag,                       // Queue full, per queue
  output logic [1:0] queue_almost_full_flag,                // Queue almost full
  output logic [1:0] queue_almost_empty_flag,               // Queue almost empty
  output logic [1:0] queue_empty_flag                       // Queue empty
);
  import memblk_pkg::*;

  // ****************************************************************
  // Lane helpers and shared signals
  // ****************************************************************
  function automatic logic [DW-1:0] pack9(input logic lane, input logic [NINE_W-1:0] v);
    logic [DW-1:0] w;
    w = '0;
    if (lane) begin
      w[LANE1_PAR] = v[BYTE_W];
      w[LANE1_LSB +: BYTE_W] = v[BYTE_W-1:0];
    end else begin
      w[LANE0_PAR] = v[BYTE_W];
      w[BYTE_W-1:0] = v[BYTE_W-1:0];
    end
    return w;
  endfunction

  function automatic logic [DW-1:0] unpack9(input logic lane, input logic [DW-1:0] w);
    logic [DW-1:0] v;
    v = '0;
    if (lane) begin
      v[NINE_W-1:0] = {w[LANE1_PAR], w[LANE1_LSB +: BYTE_W]};
    end else begin
      v[NINE_W-1:0] = {w[LANE0_PAR], w[BYTE_W-1:0]};
    end
    return v;
  endfunction

  logic [DW-1:0] mem [WORDS_P];
  logic [1:0][OPER_W-1:0] ra_in, ra_q, ra_use;
  logic [1:0][PW-1:0] wa_in;
  logic [1:0][DW-1:0] wd_in, wr_data, wr_mask, nxt, s1_q, out_q;
  logic [1:0][1:0] lane_in;
  logic [1:0] we_in, re_in, wr_en, wr_ok, re_eff;
  logic [1:0][AW-1:0] wr_word, rd_word;
  logic [1:0][PW-1:0] wptr_q, rptr_q;
  logic [1:0][CW-1:0] cnt_q, depth;
  logic [1:0] push, pop, q_act, full_q, afull_q, aempty_q, empty_q;
  logic [1:0][CAM_ENTRIES-1:0] cam_vld_q, cam_hit;
  logic [CAM_W-1:0] cam_val_q [2][CAM_ENTRIES];
  logic [PROD_W-1:0] const_prod;
  logic [2*MUL_W-1:0] mul_prod;
  logic [DW-1:0] coef;
  logic fifo_mode, cam_mode, two_writer, arb_on, busy_q;

  assign ra_in = {read_address_1, read_address_0};
  assign wa_in = {write_address_1, write_address_0};
  assign wd_in = {write_data_1, write_data_0};
  assign lane_in = {lane_write_enable_1, lane_write_enable_0};
  assign we_in = {write_enable_1, write_enable_0};
  assign re_in = {read_enable_1, read_enable_0};
  assign fifo_mode = (mode == MODE_FIFO);
  assign cam_mode = (mode == MODE_CAM);
  assign two_writer = !fifo_mode && !cam_mode && (shape != SHAPE_X36) && (shape != SHAPE_DUAL9);
  assign arb_on = arb_en | sysbus_mode;

  // ****************************************************************
  // Queue pointers and flags
  // ****************************************************************
  for (genvar q = 0; q < 2; q++) begin : g_queue
    logic [CW-1:0] cnt_d;
    logic [PW-1:0] thr_ae, thr_af, last;
    assign depth[q] = (shape == SHAPE_X36) ? DEPTH_X36 : (shape == SHAPE_X9) ? DEPTH_X9 : DEPTH_X18;
    assign q_act[q] = fifo_mode && ((q == 0) || (shape == SHAPE_DUAL9));
    assign push[q] = q_act[q] && we_in[q] && !full_q[q];
    assign pop[q] = q_act[q] && re_in[q] && !empty_q[q];
    assign last = depth[q][PW-1:0] - 10'h001;
    assign thr_ae = dyn_thr ? ra_in[q][PW-1:0] : ae_static;
    assign thr_af = dyn_thr ? wa_in[q] : af_static;
    assign cnt_d = cnt_q[q] + CW'(push[q]) - CW'(pop[q]);

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        wptr_q[q] <= '0;
        rptr_q[q] <= '0;
        cnt_q[q] <= '0;
      end else if (ce) begin
        if (!block_rst_n || !q_act[q]) begin
          wptr_q[q] <= '0;
          rptr_q[q] <= '0;
          cnt_q[q] <= '0;
        end else begin
          if (push[q]) begin
            wptr_q[q] <= (wptr_q[q] == last) ? '0 : wptr_q[q] + 10'h001;
          end
          if (pop[q]) begin
            rptr_q[q] <= (rptr_q[q] == last) ? '0 : rptr_q[q] + 10'h001;
          end
          cnt_q[q] <= cnt_d;
        end
      end
    end

    // Flags come from the occupancy count, so every word stays usable
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        empty_q[q] <= 1'b1;
        aempty_q[q] <= 1'b1;
        full_q[q] <= 1'b0;
        afull_q[q] <= 1'b0;
      end else if (ce) begin
        if (!block_rst_n || !q_act[q]) begin
          empty_q[q] <= 1'b1;
          aempty_q[q] <= 1'b1;
          full_q[q] <= 1'b0;
          afull_q[q] <= 1'b0;
        end else begin
          empty_q[q] <= (cnt_d == '0);
          full_q[q] <= (cnt_d == depth[q]);
          aempty_q[q] <= (cnt_d <= CW'(thr_ae));
          afull_q[q] <= ((CW + 1)'(cnt_d) + (CW + 1)'(thr_af)) >= (CW + 1)'(depth[q]);
        end
      end
    end
  end

  assign queue_full_flag = full_q;
  assign queue_almost_full_flag = afull_q;
  assign queue_almost_empty_flag = aempty_q;
  assign queue_empty_flag = empty_q;

  // ****************************************************************
  // Write ports, lanes and arbitration
  // ****************************************************************
  for (genvar p = 0; p < 2; p++) begin : g_wport
    logic [PW-1:0] a;
    logic [AW:0] sum;
    always_comb begin
      a = fifo_mode ? wptr_q[(shape == SHAPE_DUAL9) ? p : 0] : ((shape == SHAPE_X36) ? wa_in[0] : wa_in[p]);
      sum = {1'b0, split_words} + {1'b0, a[AW-1:0]};
      wr_word[p] = a[AW-1:0];
      wr_data[p] = wd_in[p];
      wr_mask[p] = ({DW{lane_in[p][0]}} & LANE0_MASK) | ({DW{lane_in[p][1]}} & LANE1_MASK);
      if (fifo_mode) begin
        wr_mask[p] = FULL_MASK;
        wr_en[p] = (p == 0) ? push[0] : (shape == SHAPE_X36) ? push[0] : (shape == SHAPE_DUAL9) && push[1];
      end else begin
        wr_en[p] = we_in[p] && !cam_mode;
      end
      unique case (shape)
        SHAPE_X36: begin
          wr_word[p] = {p[0], a[AW-2:0]};
        end
        SHAPE_X9: begin
          wr_word[p] = a[PW-1:1];
          wr_mask[p] = a[0] ? LANE1_MASK : LANE0_MASK;
          wr_data[p] = pack9(a[0], wd_in[p][NINE_W-1:0]);
        end
        SHAPE_DUAL9: begin
          wr_mask[p] = (p == 1) ? LANE1_MASK : LANE0_MASK;
          wr_data[p] = pack9(p[0], wd_in[p][NINE_W-1:0]);
        end
        SHAPE_SPLIT: begin
          if (!fifo_mode) begin
            wr_word[p] = (p == 1) ? sum[AW-1:0] : a[AW-1:0];
            wr_en[p] = wr_en[p] && ((p == 1) ? !sum[AW] : (a[AW-1:0] < split_words));
          end
        end
        default: begin
          wr_word[p] = a[AW-1:0];
        end
      endcase
    end
  end

  // With arb_en or sysbus_mode set in a two-writer setting, the second port wins; the first port write is dropped in that cycle
  assign wr_ok[1] = wr_en[1];
  assign wr_ok[0] = wr_en[0] && !(arb_on && two_writer && wr_en[1]);

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (wr_ok[p]) begin
          mem[wr_word[p]] <= (mem[wr_word[p]] & ~wr_mask[p]) | (wr_data[p] & wr_mask[p]);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      busy_q <= wr_en[1] && two_writer;
    end
  end
  assign busy = busy_q;

  // ****************************************************************
  // Read address / operand registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ra_q <= '0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (re_in[p]) begin
          ra_q[p] <= ra_in[p];
        end
      end
    end
  end
  assign ra_use[0] = read_reg_en ? ra_q[0] : ra_in[0];
  assign ra_use[1] = read_reg_en ? ra_q[1] : ra_in[1];

  // ****************************************************************
  // Multipliers
  // ****************************************************************
  assign coef = mem[COEF_WORD];
  assign const_prod = const_byte ? PROD_W'(coef[BYTE_W-1:0] * ra_use[0]) :
                               PROD_W'(coef[OPER_W-1:0] * ra_use[0][BYTE_W-1:0]);
  assign mul_prod = ra_use[0][MUL_W-1:0] * ra_use[1][MUL_W-1:0];

  // ****************************************************************
  // Content-addressable memory
  // ****************************************************************
  for (genvar u = 0; u < 2; u++) begin : g_cam
    logic [CAM_ENTRIES-1:0] m;
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        cam_vld_q[u] <= '0;
      end else if (ce && cam_mode && we_in[u]) begin
        if (wd_in[u][CAM_CLR_BIT]) begin
          cam_vld_q[u] <= '0;
        end else begin
          cam_vld_q[u][wd_in[u][CAM_IDX_W-1:0]] <= 1'b1;
          cam_val_q[u][wd_in[u][CAM_IDX_W-1:0]] <= wa_in[u][CAM_W-1:0];
        end
      end
    end
    for (genvar i = 0; i < CAM_ENTRIES; i++) begin : g_ent
      assign m[i] = cam_vld_q[u][i] && (cam_val_q[u][i] == ra_use[u][CAM_W-1:0]);
    end
    assign cam_hit[u] = wd_in[u][CAM_SINGLE_BIT] ? (m & (~m + 16'h0001)) : m;
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  for (genvar p = 0; p < 2; p++) begin : g_rport
    logic [PW-1:0] a;
    logic [AW:0] sum;
    always_comb begin
      a = fifo_mode ? rptr_q[(shape == SHAPE_DUAL9) ? p : 0] : ((shape == SHAPE_X36) ? ra_use[0][PW-1:0] :
          ra_use[p][PW-1:0]);
      sum = {1'b0, split_words} + {1'b0, a[AW-1:0]};
      rd_word[p] = a[AW-1:0];
      unique case (shape)
        SHAPE_X36: rd_word[p] = {p[0], a[AW-2:0]};
        SHAPE_X9: rd_word[p] = a[PW-1:1];
        SHAPE_SPLIT: rd_word[p] = (p == 1 && !fifo_mode) ? sum[AW-1:0] : a[AW-1:0];
        default: rd_word[p] = a[AW-1:0];
      endcase
      if (fifo_mode) begin
        re_eff[p] = (p == 0) ? pop[0] : (shape == SHAPE_X36) ? pop[0] : (shape == SHAPE_DUAL9) && pop[1];
      end else begin
        re_eff[p] = re_in[p];
      end
      unique case (mode)
        MODE_CONST: nxt[p] = (p == 0) ? const_prod[DW-1:0] : DW'(const_prod[PROD_W-1:DW]);
        MODE_MUL8: nxt[p] = (p == 0) ? DW'(mul_prod) : '0;
        MODE_CAM: nxt[p] = DW'(cam_hit[p]);
        default: begin
          if (shape == SHAPE_X9) begin
            nxt[p] = unpack9(a[0], mem[rd_word[p]]);
          end else if (shape == SHAPE_DUAL9) begin
            nxt[p] = unpack9(p[0], mem[rd_word[p]]);
          end else begin
            nxt[p] = mem[rd_word[p]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_q <= '0;
      out_q <= '0;
    end else if (ce) begin
      if (!block_rst_n) begin
        s1_q <= '0;
        out_q <= '0;
      end else begin
        for (int p = 0; p < 2; p++) begin
          if (re_eff[p]) begin
            s1_q[p] <= nxt[p];
          end
          if (out_reg_en) begin
            out_q[p] <= s1_q[p];
          end else if (re_eff[p]) begin
            out_q[p] <= nxt[p];
          end
        end
      end
    end
  end
  assign read_data_0 = out_q[0];
  assign read_data_1 = out_q[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  busy_marks_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && wr_en[1] && two_writer) |=> busy) else $error("busy missed second port write");
  arb_blocks_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arb_on && two_writer && wr_en[1]) |-> !wr_ok[0]) else $error("dual write not blocked");
  full_holds_ptr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && block_rst_n && q_act[0] && full_q[0] && !re_in[0]) |=> $stable(wptr_q[0]))
    else $error("write accepted while full");
  empty_holds_ptr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && block_rst_n && q_act[0] && empty_q[0] && !we_in[0]) |=> $stable(rptr_q[0]))
    else $error("read accepted while empty");
  ptr_reset_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && !block_rst_n) |=> (empty_q[0] && aempty_q[0] && !full_q[0] && !afull_q[0] && cnt_q[0] == '0))
    else $error("queue reset left flags wrong");
  full_flag_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    q_act[0] |-> (full_q[0] == (cnt_q[0] == depth[0]) && empty_q[0] == (cnt_q[0] == '0)))
    else $error("queue flag disagrees with count");
  out_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && !block_rst_n) |=> (read_data_0 == '0 && read_data_1 == '0)) else $error("outputs not cleared");
  read_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && block_rst_n && !out_reg_en && !re_eff[0]) |=> $stable(read_data_0))
    else $error("read data changed without enable");
  mul8_product_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && block_rst_n && mode == MODE_MUL8 && !read_reg_en && !out_reg_en && read_enable_0)
    |=> read_data_0 == DW'($past(read_address_0[MUL_W-1:0]) * $past(read_address_1[MUL_W-1:0])))
    else $error("8x8 product wrong");
  cam_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && cam_mode && we_in[0] && wd_in[0][CAM_CLR_BIT]) |=> cam_vld_q[0] == '0)
    else $error("CAM clear left entries");

endmodule

// >>> test/fabric_user.sv
// User fabric model that drives the request side of both memory ports
`timescale 1ns/1ps

module fabric_user (
  input wire logic clk_sys, // System clock
  output logic [15:0] ra [2], // Read addresses or operands
  output logic [9:0] wa [2], // Write addresses
  output logic [17:0] wd [2], // Write data
  output logic [1:0] lwe [2], // Lane enables
  output logic [1:0] re, // Read enables
  output logic [1:0] we // Write enables
);
  initial begin
    re = 2'h0;
    we = 2'h0;
    for (int i = 0; i < 2; i++) begin
      ra[i] = 16'h0;
      wa[i] = 10'h0;
      wd[i] = 18'h0;
      lwe[i] = 2'h0;
    end
  end

  // ****************************************************************
  // Request set-up and release
  // ****************************************************************
  task put(input int p, input logic w, input logic r, input logic [1:0] l, input logic [9:0] a,
    input logic [17:0] d, input logic [15:0] b);
    we[p] <= w;
    re[p] <= r;
    lwe[p] <= l;
    wa[p] <= a;
    wd[p] <= d;
    ra[p] <= b;
  endtask

  // Enables last exactly one edge, then the result is looked at mid-cycle
  task go;
    @(posedge clk_sys);
    we <= 2'h0;
    re <= 2'h0;
    @(negedge clk_sys);
  endtask
endmodule

// >>> test/tb_multimode_block_ram.sv
// Self-checking bench for the multimode embedded memory block
`timescale 1ns/1ps

module tb_multimode_block_ram;
  import memblk_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic block_rst_n = 1'b1;
  mode_e mode = MODE_RAM;
  shape_e shape = SHAPE_X18;
  logic read_reg_en = 1'b0;
  logic out_reg_en = 1'b0;
  logic arb_en = 1'b1;
  logic dyn_thr = 1'b0;
  logic [9:0] ae_static = 10'h1;
  logic [9:0] af_static = 10'h1;
  logic [17:0] rd0, rd1;
  logic busy;
  logic [1:0] qf, qaf, qae, qe;
  logic [15:0] ra [2];
  logic [9:0] wa [2];
  logic [17:0] wd [2];
  logic [1:0] lwe [2];
  logic [1:0] re, we;
  int n_mismatch = 0;
  int total_checks = 0;

  always #10 clk_sys = ~clk_sys;

  fabric_user fab (.clk_sys(clk_sys), .ra(ra), .wa(wa), .wd(wd), .lwe(lwe), .re(re), .we(we));

  multimode_block_ram u_multimode_block_ram (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
    .block_rst_n(block_rst_n), .mode(mode), .shape(shape), .split_words(9'h0), .read_reg_en(read_reg_en),
    .out_reg_en(out_reg_en), .arb_en(arb_en), .sysbus_mode(1'b0), .dyn_thr(dyn_thr), .ae_static(ae_static),
    .af_static(af_static), .const_byte(1'b0), .read_address_0(ra[0]), .read_address_1(ra[1]),
    .write_address_0(wa[0]), .write_address_1(wa[1]), .lane_write_enable_0(lwe[0]),
    .lane_write_enable_1(lwe[1]), .read_enable_0(re[0]), .read_enable_1(re[1]), .write_enable_0(we[0]),
    .write_enable_1(we[1]), .write_data_0(wd[0]), .write_data_1(wd[1]), .read_data_0(rd0),
    .read_data_1(rd1), .busy(busy), .queue_full_flag(qf), .queue_almost_full_flag(qaf),
    .queue_almost_empty_flag(qae), .queue_empty_flag(qe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task check(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task op(input int p, input logic w, input logic r, input logic [1:0] l, input logic [9:0] a,
    input logic [17:0] d, input logic [15:0] b);
    @(posedge clk_sys);
    fab.put(p, w, r, l, a, d, b);
    fab.go;
  endtask

  task blk_rst;
    @(posedge clk_sys);
    block_rst_n <= 1'b0;
    @(posedge clk_sys);
    block_rst_n <= 1'b1;
    @(negedge clk_sys);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check({10'h0, qe, qae, qf, qaf}, 18'h000f0);
    op(0, 1, 0, 2'h3, 10'h5, 18'h3a5c3, 16'h0);
    op(0, 1, 0, 2'h1, 10'h5, 18'h0, 16'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h5);
    check(rd0, 18'h3a5c3 & LANE1_MASK);
    op(0, 0, 0, 2'h0, 10'h0, 18'h0, 16'h7);
    check(rd0, 18'h3a5c3 & LANE1_MASK);
    op(0, 1, 0, 2'h3, 10'h7, 18'h00055, 16'h0);
    @(posedge clk_sys);
    fab.put(0, 1, 0, 2'h3, 10'h7, 18'h00011, 16'h0);
    fab.put(1, 1, 0, 2'h3, 10'h8, 18'h00022, 16'h0);
    fab.go;
    check({17'h0, busy}, 18'h1);
    op(1, 0, 1, 2'h0, 10'h0, 18'h0, 16'h7);
    check(rd1, 18'h00055);
    check({17'h0, busy}, 18'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h8);
    check(rd0, 18'h00022);
    blk_rst;
    check(rd0, 18'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h8);
    check(rd0, 18'h00022);
    @(posedge clk_sys);
    mode <= MODE_MUL8;
    @(posedge clk_sys);
    fab.put(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'hd7);
    fab.put(1, 0, 1, 2'h0, 10'h0, 18'h0, 16'h3b);
    fab.go;
    check({2'h0, rd0[15:0]}, 18'h0d7 * 18'h03b);
    @(posedge clk_sys);
    mode <= MODE_FIFO;
    blk_rst;
    check({16'h0, qe[0], qae[0]}, 18'h3);
    op(0, 1, 0, 2'h3, 10'h0, 18'h1a, 16'h0);
    check({15'h0, qe[0], qae[0], qf[0]}, 18'h2);
    op(0, 1, 0, 2'h3, 10'h0, 18'h2b, 16'h0);
    check({15'h0, qe[0], qae[0], qf[0]}, 18'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h0);
    check(rd0, 18'h1a);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h0);
    check({17'h0, qe[0]}, 18'h1);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h0);
    check(rd0, 18'h2b);
    @(posedge clk_sys);
    dyn_thr <= 1'b1;
    op(0, 1, 0, 2'h3, 10'h1ff, 18'h3c, 16'h0);
    check({16'h0, qaf[0], qae[0]}, 18'h2);
    @(posedge clk_sys);
    mode <= MODE_CAM;
    op(0, 1, 0, 2'h0, 10'h9c, 18'h3, 16'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h9c);
    check({17'h0, rd0[3]}, 18'h1);
    op(0, 1, 0, 2'h0, 10'h0, 18'h20000, 16'h0);
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h9c);
    check({2'h0, rd0[15:0]}, 18'h0);
    @(posedge clk_sys);
    mode <= MODE_RAM;
    shape <= SHAPE_X36;
    @(posedge clk_sys);
    fab.put(0, 1, 0, 2'h3, 10'h3, 18'h11111, 16'h0);
    fab.put(1, 1, 0, 2'h3, 10'h0, 18'h22222, 16'h0);
    fab.go;
    @(posedge clk_sys);
    fab.put(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h3);
    fab.put(1, 0, 1, 2'h0, 10'h0, 18'h0, 16'h0);
    fab.go;
    check(rd0, 18'h11111);
    check(rd1, 18'h22222);
    @(posedge clk_sys);
    shape <= SHAPE_X18;
    op(0, 1, 0, 2'h3, 10'h0, 18'h01234, 16'h0);
    @(posedge clk_sys);
    mode <= MODE_CONST;
    @(posedge clk_sys);
    fab.put(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'hab);
    fab.put(1, 0, 1, 2'h0, 10'h0, 18'h0, 16'h0);
    fab.go;
    check(rd0, 18'h028bc);
    check(rd1, 18'h00003);
    @(posedge clk_sys);
    mode <= MODE_RAM;
    out_reg_en <= 1'b1;
    op(0, 0, 1, 2'h0, 10'h0, 18'h0, 16'h8);
    check(rd0, 18'h028bc);
    @(negedge clk_sys);
    check(rd0, 18'h00022);
    end_sim;
  end
endmodule
